/* File: src/asbs_defines.svh */
// Constants of the ALU status and bank select register.
// Assumes inclusion by bare name from the design and the bench.
`ifndef ASBS_DEFINES_SVH
`define ASBS_DEFINES_SVH
// Register index and byte address on the APB
`define ASBS_STATUS_IDX       12'h003
`define ASBS_STATUS_ADDR      12'h00c
// Field positions
`define ASBS_BIT_IND          7
`define ASBS_BIT_DHI          6
`define ASBS_BIT_DLO          5
`define ASBS_BIT_TO           4
`define ASBS_BIT_PD           3
`define ASBS_BIT_Z            2
`define ASBS_BIT_DC           1
`define ASBS_BIT_C            0
// Bits software may write, bits a flag-affecting op owns
`define ASBS_SW_MASK          8'he7
`define ASBS_FLAG_MASK        8'h07
// Power-up value: both reset-cause flags high
`define ASBS_STATUS_RST       8'h18
// Bank geometry
`define ASBS_BANK_BYTES       9'h080
`define ASBS_IND_BASE_HI      9'h100
`endif

/* File: src/asbs_pkg.sv */
// Types of the ALU status and bank select register.
// Assumes the defines header is on the include path.
package asbs_pkg;
   // Operation class reported by the core sequencer
   typedef enum logic [2:0] {
      asbs_op_add,
      asbs_op_sub,
      asbs_op_rotl,
      asbs_op_rotr,
      asbs_op_logic,
      asbs_op_move
   } asbs_op_t;
endpackage

/* File: src/asbs_status.sv */
// ALU flag, reset-cause and bank select status register with APB access.
// Assumes a core that issues one operation pulse with operands per cycle
// and single-cycle pulses for watchdog clear, sleep and watchdog time-out.
`timescale 1ns/1ps
`default_nettype none
`include "asbs_defines.svh"

module asbs_status #(
   parameter int ADDR_W = 12,                  // APB address width
   parameter int DATA_W = 8                    // ALU operand width
) (
   input  wire logic              pclk,        // Clock, 50 MHz
   input  wire logic              presetn,     // Power-up reset, low
   input  wire logic              psel,        // APB select
   input  wire logic              penable,     // APB access phase
   input  wire logic              pwrite,      // APB write
   input  wire logic [ADDR_W-1:0] paddr,       // APB byte address
   input  wire logic [31:0]       pwdata,      // APB write data
   output logic [31:0]            prdata,      // APB read data
   output logic                   pready,      // APB ready
   output logic                   pslverr,     // APB error, unmapped
   input  wire logic              op_valid,    // Core operation pulse
   input  wire asbs_pkg::asbs_op_t op_code,    // Operation class
   input  wire logic [DATA_W-1:0] op_a,        // First operand
   input  wire logic [DATA_W-1:0] op_b,        // Second operand/value
   input  wire logic              op_dest_stat,// Result goes to status
   input  wire logic              wdt_clear,   // Watchdog clear pulse
   input  wire logic              sleep_req,   // Sleep pulse
   input  wire logic              wdt_timeout, // Watchdog time-out pulse
   output logic [DATA_W-1:0]      alu_result,  // Last operation result
   output logic [7:0]             status,      // Whole status byte
   output logic                   indirect_bank_select,  // Indirect bit
   output logic                   direct_bank_select_hi, // Direct high
   output logic                   direct_bank_select_lo, // Direct low
   output logic                   timeout_flag,          // Time-out
   output logic                   powerdown_flag,        // Power-down
   output logic                   zero_flag,             // Zero
   output logic                   digit_carry_flag,      // Digit carry
   output logic                   carry_flag,            // Carry
   output logic [8:0]             direct_bank_base,      // Direct base
   output logic [8:0]             indirect_bank_base     // Indirect base
);

   // Elaboration checks
   initial begin
      // The status data path takes result bits 7:5, so a byte is needed
      if (DATA_W < 8) begin
         $error("asbs_status: DATA_W must be at least 8");
      end
      if (ADDR_W < 4) begin
         $error("asbs_status: ADDR_W must be at least 4");
      end
   end

   // Operating notes for integrators
   // - One operation pulse per cycle from the core
   // - Operands and class matter with the pulse only
   // - Results land at the edge that takes the pulse
   // - Flags and result visible one cycle later
   // - Back to back operations need no gap
   // - A rotate reads the carry held before it
   // - Status write by the core beats an APB write
   // - Computed flags beat any data write
   // - Reset-cause bits never follow written data
   // - Setting events beat a watchdog time-out
   // - Watchdog clear beats a sleep in one cycle
   // - Event pulses last one cycle each
   // - A held event pulse reapplies every cycle
   // - APB slave answers with no wait states
   // - Ready is tied high for that reason
   // - Read data is the status at the setup cycle
   // - A core update in that cycle shows next read
   // - Unmapped addresses answer with an error
   // - Unmapped writes are dropped and answer with an error
   // - Unmapped reads return zero
   // - Upper 24 data bits read zero
   // - Upper 24 data bits ignored on write
   // - Address decode is a full compare
   // - Bank bases come from registered bits
   // - Bank bases settle one cycle after a write
   // - Zero, digit carry and carry reset low
   // - Bank select bits reset low, bank 0 direct
   // - Indirect base resets to the low half
   // - Both reset-cause bits reset high
   // - Rotates touch only the carry flag
   // - Logic class touches only the zero flag
   // - Moves touch no flag unless status is the destination
   // - Illegal codes change nothing unless status is the destination
   // - Subtract flags read as no-borrow when high
   // - Digit carry is taken from a nibble adder
   // - The nibble adder sees the same carry in
   // - Wider operands keep status on the low byte

   // Status and result state
   logic [7:0]        stat_q;
   logic [7:0]        stat_d;
   logic [DATA_W-1:0] res_q;
   logic [DATA_W-1:0] res_d;
   logic [31:0]       rdata_q;
   logic [31:0]       rdata_d;
   logic [DATA_W-1:0] b_eff;
   logic              cin;
   logic [DATA_W:0]   sum;
   logic [4:0]        nib;
   logic              hit;
   logic              apb_wr;
   logic              apb_setup;
   logic              fl_z;
   logic              fl_dc;
   logic              fl_c;
   logic              fl_en;
   logic [2:0]        fl_upd;

   // APB decode
   assign hit       = (paddr == ADDR_W'(`ASBS_STATUS_ADDR));
   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite & hit;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~hit;

   // Adder: subtraction adds the two's complement
   // One shared adder serves add and subtract
   // Carry in of one completes the complement
   // The nibble sum gives the digit carry
   always_comb begin
      b_eff = op_b;
      cin   = 1'b0;
      if (op_code == asbs_pkg::asbs_op_sub) begin
         b_eff = ~op_b;
         cin   = 1'b1;
      end
      sum = {1'b0, op_a} + {1'b0, b_eff} + {{DATA_W{1'b0}}, cin};
      nib = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
   end

   // Result and flags of the current operation
   // Flags default to their held values
   // Update mask: bit 2 zero, bit 1 digit, bit 0 carry
   // Result holds when no operation is taken
   always_comb begin
      res_d  = res_q;
      fl_z   = stat_q[`ASBS_BIT_Z];
      fl_dc  = stat_q[`ASBS_BIT_DC];
      fl_c   = stat_q[`ASBS_BIT_C];
      fl_upd = 3'h0;
      if (op_valid) begin
         unique case (op_code)
            asbs_pkg::asbs_op_add,
            asbs_pkg::asbs_op_sub: begin
               res_d  = sum[DATA_W-1:0];
               fl_c   = sum[DATA_W];
               fl_dc  = nib[4];
               fl_z   = (sum[DATA_W-1:0] == '0);
               fl_upd = 3'h7;
            end
            asbs_pkg::asbs_op_rotl: begin
               res_d  = {op_a[DATA_W-2:0], stat_q[`ASBS_BIT_C]};
               fl_c   = op_a[DATA_W-1];
               fl_upd = 3'h1;
            end
            asbs_pkg::asbs_op_rotr: begin
               res_d  = {stat_q[`ASBS_BIT_C], op_a[DATA_W-1:1]};
               fl_c   = op_a[0];
               fl_upd = 3'h1;
            end
            asbs_pkg::asbs_op_logic: begin
               res_d  = op_b;
               fl_z   = (op_b == '0);
               fl_upd = 3'h4;
            end
            asbs_pkg::asbs_op_move: begin
               res_d  = op_b;
            end
            // Unused codes hold result and flags
            default: begin
               res_d  = res_q;
            end
         endcase
      end
      fl_en = (fl_upd != 3'h0);
   end

   // Status next value
   // Order of the steps below sets priority
   // APB write first, core write over it
   // Computed flags over both data writes
   // Reset-cause events last of all
   always_comb begin
      stat_d = stat_q;
      // Software write touches only bank and ALU flag bits
      if (apb_wr) begin
         stat_d = (stat_q & ~`ASBS_SW_MASK) | (pwdata[7:0] & `ASBS_SW_MASK);
      end
      // Core write with status as destination
      if (op_valid && op_dest_stat) begin
         if (fl_en) begin
            // Flag bits hold or come from the op, not the data
            stat_d = (stat_q & ~8'he0) | (res_d[7:0] & 8'he0);
         end else begin
            stat_d = (stat_q & ~`ASBS_SW_MASK) | (res_d[7:0] & `ASBS_SW_MASK);
         end
      end
      // Flags computed by the operation win over any data write
      if (fl_upd[2]) begin
         stat_d[`ASBS_BIT_Z] = fl_z;
      end
      if (fl_upd[1]) begin
         stat_d[`ASBS_BIT_DC] = fl_dc;
      end
      if (fl_upd[0]) begin
         stat_d[`ASBS_BIT_C] = fl_c;
      end
      // Reset-cause events; a setting event wins over time-out
      if (wdt_timeout) begin
         stat_d[`ASBS_BIT_TO] = 1'b0;
      end
      if (sleep_req) begin
         stat_d[`ASBS_BIT_TO] = 1'b1;
         stat_d[`ASBS_BIT_PD] = 1'b0;
      end
      if (wdt_clear) begin
         stat_d[`ASBS_BIT_TO] = 1'b1;
         stat_d[`ASBS_BIT_PD] = 1'b1;
      end
   end

   // Read data captured in the setup cycle
   // Value stands through the access phase
   always_comb begin
      rdata_d = rdata_q;
      if (apb_setup) begin
         rdata_d = hit ? {24'h0, stat_q} : 32'h0;
      end
   end

   // State registers; power-up sets both reset-cause flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q  <= `ASBS_STATUS_RST;
         res_q   <= '0;
         rdata_q <= 32'h0;
      end else begin
         stat_q  <= stat_d;
         res_q   <= res_d;
         rdata_q <= rdata_d;
      end
   end

   // Bank base addresses for the data-memory decoder
   always_comb begin
      unique case (stat_q[`ASBS_BIT_DHI:`ASBS_BIT_DLO])
         2'b00: begin
            direct_bank_base = 9'h000;
         end
         2'b01: begin
            direct_bank_base = `ASBS_BANK_BYTES;
         end
         2'b10: begin
            direct_bank_base = 9'(2 * `ASBS_BANK_BYTES);
         end
         2'b11: begin
            direct_bank_base = 9'(3 * `ASBS_BANK_BYTES);
         end
      endcase
      // Indirect access picks the upper or lower half
      indirect_bank_base = stat_q[`ASBS_BIT_IND] ? `ASBS_IND_BASE_HI : 9'h000;
   end

   // Outputs from flip-flops
   assign prdata                = rdata_q;
   assign alu_result            = res_q;
   assign status                = stat_q;
   assign indirect_bank_select  = stat_q[`ASBS_BIT_IND];
   assign direct_bank_select_hi = stat_q[`ASBS_BIT_DHI];
   assign direct_bank_select_lo = stat_q[`ASBS_BIT_DLO];
   assign timeout_flag          = stat_q[`ASBS_BIT_TO];
   assign powerdown_flag        = stat_q[`ASBS_BIT_PD];
   assign zero_flag             = stat_q[`ASBS_BIT_Z];
   assign digit_carry_flag      = stat_q[`ASBS_BIT_DC];
   assign carry_flag            = stat_q[`ASBS_BIT_C];

endmodule // asbs_status
`default_nettype wire

/* File: test/asbs_core_model.sv */
// Core sequencer model: issues one ALU operation pulse with its operands.
// Assumes the bench calls issue() right after a rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module asbs_core_model (
   input  wire logic          pclk,         // Core clock
   output var logic           op_valid,     // Operation pulse
   output var asbs_pkg::asbs_op_t op_code,  // Operation class
   output var logic [7:0]     op_a,         // First operand
   output var logic [7:0]     op_b,         // Second operand
   output var logic           op_dest_stat  // Result to status
);
   initial begin
      op_valid = 1'b0;
      op_code = asbs_pkg::asbs_op_move;
      op_a = 8'h00;
      op_b = 8'h00;
      op_dest_stat = 1'b0;
   end
   // One-cycle pulse, operands scrambled once released
   task automatic issue(input asbs_pkg::asbs_op_t c, input logic [7:0] a, b, input logic dst);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_code <= c;
      op_a <= a;
      op_b <= b;
      op_dest_stat <= dst;
      @(posedge pclk);
      op_valid <= 1'b0;
      op_a <= ~a;
      op_b <= ~b;
      op_dest_stat <= ~dst;
   endtask
endmodule // asbs_core_model
`default_nettype wire

/* File: test/asbs_status_checker.sv */
// Concurrent checks on the status register ports.
// Assumes default widths of asbs_status; bound below.
`timescale 1ns/1ps
`default_nettype none
module asbs_checker (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       op_valid,
   input wire asbs_pkg::asbs_op_t op_code,
   input wire logic [7:0] op_a,
   input wire logic [7:0] op_b,
   input wire logic       op_dest_stat,
   input wire logic       wdt_clear,
   input wire logic       sleep_req,
   input wire logic       wdt_timeout,
   input wire logic [7:0] alu_result,
   input wire logic [7:0] status,
   input wire logic       timeout_flag,
   input wire logic       powerdown_flag,
   input wire logic       carry_flag,
   input wire logic [8:0] direct_bank_base,
   input wire logic [8:0] indirect_bank_base
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Reference sums: plain add and add of complement
   wire logic [8:0] sa = {1'b0, op_a} + {1'b0, op_b};
   wire logic [8:0] ss = {1'b0, op_a} + {1'b0, ~op_b} + 9'h001;
   wire logic [4:0] da = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
   wire logic [4:0] ds = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + 5'h01;
   sequence s_add; op_valid && op_code == asbs_pkg::asbs_op_add; endsequence
   sequence s_sub; op_valid && op_code == asbs_pkg::asbs_op_sub; endsequence
   property p_ind; indirect_bank_base == (status[7] ? 9'h100 : 9'h000); endproperty
   a_ind: assert property (p_ind) else $error("indirect base wrong");
   property p_dir; direct_bank_base == {status[6:5], 7'h00}; endproperty
   a_dir: assert property (p_dir) else $error("direct base wrong");
   property p_add; s_add |=> status[2:0] == $past({sa[7:0] == 8'h00, da[4], sa[8]}); endproperty
   a_add: assert property (p_add) else $error("add flags wrong");
   property p_sub; s_sub |=> status[2:0] == $past({ss[7:0] == 8'h00, ds[4], ss[8]}); endproperty
   a_sub: assert property (p_sub) else $error("sub flags wrong");
   property p_rl;
      op_valid && op_code == asbs_pkg::asbs_op_rotl
      |=> carry_flag == $past(op_a[7]) && alu_result == $past({op_a[6:0], carry_flag});
   endproperty
   a_rl: assert property (p_rl) else $error("rotate left wrong");
   property p_rr; op_valid && op_code == asbs_pkg::asbs_op_rotr |=> carry_flag == $past(op_a[0]);
   endproperty
   a_rr: assert property (p_rr) else $error("rotate right wrong");
   property p_dst; s_add ##0 op_dest_stat |=> status[7:5] == $past(sa[7:5]); endproperty
   a_dst: assert property (p_dst) else $error("status destination wrong");
   property p_hold; !(wdt_clear || sleep_req || wdt_timeout) |=> $stable(status[4:3]); endproperty
   a_hold: assert property (p_hold) else $error("reset-cause bits moved");
   property p_clr; wdt_clear |=> timeout_flag && powerdown_flag; endproperty
   a_clr: assert property (p_clr) else $error("watchdog clear wrong");
   property p_slp; sleep_req && !wdt_clear |=> timeout_flag && !powerdown_flag; endproperty
   a_slp: assert property (p_slp) else $error("sleep wrong");
   property p_wto; wdt_timeout && !sleep_req && !wdt_clear |=> !timeout_flag; endproperty
   a_wto: assert property (p_wto) else $error("time-out wrong");
endmodule // asbs_checker
bind asbs_status asbs_checker u_asbs_checker (.*);
`default_nettype wire

/* File: test/alu_status_bank_select_bench.sv */
// Bench: APB master, event pulses and random ALU operations on the status register.
// Assumes the core model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "asbs_defines.svh"
module alu_status_bank_select_bench;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r = 32'h52d4;
   logic        pready, pslverr, op_valid, op_dest_stat;
   logic [2:0]  ev = 3'h0;
   logic [7:0]  op_a, op_b, alu_result, status, e, a, b, bs, pins, res;
   logic [8:0]  dbase, ibase, s;
   logic [4:0]  d;
   logic [32:0] q[$];
   int          bad_count = 0, check_count = 0, n;
   asbs_pkg::asbs_op_t op_code;
   asbs_core_model u_asbs_core_model (.*);
   asbs_status u_asbs_status (.*, .wdt_clear(ev[2]), .sleep_req(ev[1]), .wdt_timeout(ev[0]),
      .indirect_bank_select(pins[7]), .direct_bank_select_hi(pins[6]),
      .direct_bank_select_lo(pins[5]), .timeout_flag(pins[4]), .powerdown_flag(pins[3]),
      .zero_flag(pins[2]), .digit_carry_flag(pins[1]), .carry_flag(pins[0]),
      .direct_bank_base(dbase), .indirect_bank_base(ibase));
   initial forever #10 pclk = ~pclk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // APB transfer; a read leaves its expected {pslverr, prdata} in the queue
   task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] wd,
                      input logic [32:0] x);
      @(posedge pclk);
      if (!w) q.push_back(x);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         if (++n > 40) begin
            bad_count++;
            finish_test();
         end
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Read monitor takes the oldest note at each completed read
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && q.size() > 0) begin
         cmp("prdata", q[0][31:0], prdata);
         cmp("pslverr", {31'h0, q[0][32]}, {31'h0, pslverr});
         void'(q.pop_front());
      end
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      e = `ASBS_STATUS_RST;
      apb(0, `ASBS_STATUS_ADDR, 8'h00, {25'h0, e});
      apb(1, 12'h010, 8'hff, 33'h0);
      apb(0, 12'h010, 8'h00, 33'h100000000);
      apb(1, `ASBS_STATUS_ADDR, 8'h00, 33'h0);
      apb(0, `ASBS_STATUS_ADDR, 8'h00, {25'h0, e});
      for (int j = 0; j < 3; j++) begin
         @(posedge pclk);
         ev <= 3'h1 << j;
         @(posedge pclk);
         ev <= 3'h0;
         e[4:3] = (j == 0) ? {1'b0, e[3]} : (j == 1) ? 2'b10 : 2'b11;
         apb(0, `ASBS_STATUS_ADDR, 8'h00, {25'h0, e});
         cmp("flag pins", {24'h0, e}, {24'h0, pins});
      end
      for (int k = 0; k < 8; k++) begin
         apb(1, `ASBS_STATUS_ADDR, {k[2:0], 5'h07}, 33'h0);
         @(negedge pclk);
         cmp("direct base", {23'h0, k[1:0], 7'h00}, {23'h0, dbase});
         cmp("indirect base", {23'h0, k[2], 8'h00}, {23'h0, ibase});
      end
      e = 8'hff;
      for (int i = 0; i < 48; i++) begin
         r = xs(r);
         a = r[7:0];
         b = r[15:8];
         bs = r[16] ? ~b : b;
         s = {1'b0, a} + {1'b0, bs} + {8'h0, r[16]};
         d = {1'b0, a[3:0]} + {1'b0, bs[3:0]} + {4'h0, r[16]};
         res = r[17] ? (r[16] ? {e[0], a[7:1]} : {a[6:0], e[0]}) : s[7:0];
         if (!r[17]) begin
            e[2:0] = {s[7:0] == 8'h00, d[4], s[8]};
            if (r[18]) e[7:5] = s[7:5];
         end else
            e[0] = r[16] ? a[0] : a[7];
         u_asbs_core_model.issue(asbs_pkg::asbs_op_t'({1'b0, r[17:16]}), a, b, r[18] & ~r[17]);
         apb(0, `ASBS_STATUS_ADDR, 8'h00, {25'h0, e});
         cmp("alu result", {24'h0, res}, {24'h0, alu_result});
         cmp("flag pins", {24'h0, e}, {24'h0, pins});
      end
      finish_test();
   end
endmodule // alu_status_bank_select_bench
`default_nettype wire
